//--- hw/iwd_pkg.sv
// Shared constants, types and timing figures of the instruction decoder.
package iwd_pkg;
    localparam int WORD_W = 24;
    localparam int OPC_W = 6;
    localparam int VAR_W = 3;
    localparam int ADDR_W = 15;
    localparam int NUM_IDX = 6;
    localparam int IRQ_LEVELS = 24;
    localparam int IRQ_LVL_W = 5;
    localparam int TMR_W = 20;
    localparam int CNT_W = 8;

    // Field positions inside a word.
    localparam int OPC_LSB = 18;
    localparam int VAR_LSB = 15;
    localparam int IND_VAR_LSB = 21;

    localparam logic [VAR_W-1:0] VAR_DIRECT = 3'h0;
    localparam logic [VAR_W-1:0] VAR_INDIRECT = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_MINUS_ONE = 15'h7fff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

    // Operation codes.
    localparam logic [OPC_W-1:0] OPC_ADD = 6'h01;
    localparam logic [OPC_W-1:0] OPC_SUB = 6'h02;
    localparam logic [OPC_W-1:0] OPC_MPY = 6'h03;
    localparam logic [OPC_W-1:0] OPC_DIV = 6'h04;
    localparam logic [OPC_W-1:0] OPC_SKM = 6'h05;
    localparam logic [OPC_W-1:0] OPC_SKE = 6'h06;
    localparam logic [OPC_W-1:0] OPC_PIN = 6'h07;
    localparam logic [OPC_W-1:0] OPC_AND = 6'h08;
    localparam logic [OPC_W-1:0] OPC_XOR = 6'h09;
    localparam logic [OPC_W-1:0] OPC_IOR = 6'h0a;
    localparam logic [OPC_W-1:0] OPC_SST = 6'h0b;
    localparam logic [OPC_W-1:0] OPC_PCB = 6'h0c;
    localparam logic [OPC_W-1:0] OPC_PDT = 6'h0d;
    localparam logic [OPC_W-1:0] OPC_DJX = 6'h0e;
    localparam logic [OPC_W-1:0] OPC_SXI = 6'h0f;
    localparam logic [OPC_W-1:0] OPC_SKX = 6'h10;
    localparam logic [OPC_W-1:0] OPC_GROUP = 6'h3f;

    // Execution times in ns, and the clock period.
    localparam int CLK_NS = 10;
    localparam int T_ARITH_NS = 2000;
    localparam int T_MPY_NS = 12000;
    localparam int T_DIV_NS = 30000;
    localparam int T_SKM_NS = 4000;
    localparam int T_SKE_NS = 3000;
    localparam int T_PIN_SKIP_NS = 8000;
    localparam int T_PIN_NOSKIP_NS = 4000;
    localparam int T_LOGIC_NS = 2000;
    localparam int T_SST_NS = 7000;
    localparam int T_BLK_BASE_NS = 3000;
    localparam int T_PCB_4C_NS = 29000;
    localparam int T_PDT_4C_NS = 33000;
    localparam int T_DJX_NS = 2000;
    localparam int T_SXI_NS = 3000;
    localparam int T_SKX_NS = 4000;
    localparam int T_OTHER_NS = 2000;

    localparam int CYC_ARITH = T_ARITH_NS / CLK_NS;
    localparam int CYC_MPY = T_MPY_NS / CLK_NS;
    localparam int CYC_DIV = T_DIV_NS / CLK_NS;
    localparam int CYC_SKM = T_SKM_NS / CLK_NS;
    localparam int CYC_SKE = T_SKE_NS / CLK_NS;
    localparam int CYC_PIN_SKIP = T_PIN_SKIP_NS / CLK_NS;
    localparam int CYC_PIN_NOSKIP = T_PIN_NOSKIP_NS / CLK_NS;
    localparam int CYC_LOGIC = T_LOGIC_NS / CLK_NS;
    localparam int CYC_SST = T_SST_NS / CLK_NS;
    localparam int CYC_BLK_BASE = T_BLK_BASE_NS / CLK_NS;
    localparam int CYC_PCB_PER = T_PCB_4C_NS / (4 * CLK_NS);
    localparam int CYC_PDT_PER = T_PDT_4C_NS / (4 * CLK_NS);
    localparam int CYC_DJX = T_DJX_NS / CLK_NS;
    localparam int CYC_SXI = T_SXI_NS / CLK_NS;
    localparam int CYC_SKX = T_SKX_NS / CLK_NS;
    localparam int CYC_OTHER = T_OTHER_NS / CLK_NS;

    typedef struct packed {
        logic [OPC_W-1:0] opcode;
        logic [VAR_W-1:0] variant;
        logic [ADDR_W-1:0] addr;
    } iwd_instr_t;

    typedef struct packed {
        logic sign;
        logic [WORD_W-2:0] mag;
    } iwd_data_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RESOLVE = 3'h1,
        ST_IND_WAIT = 3'h2,
        ST_OPR_WAIT = 3'h3,
        ST_EXEC = 3'h4
    } iwd_state_t;
endpackage

//--- hw/iwd_index_regs.sv
// Six index registers with one write port and one read port.
`timescale 1ns/1ps
`default_nettype none
module iwd_index_regs
    import iwd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // Write port
    input wire logic wr_en,
    input wire logic [VAR_W-1:0] wr_sel,
    input wire logic [ADDR_W-1:0] wr_data,
    // Read port
    input wire logic [VAR_W-1:0] rd_sel,
    output logic [ADDR_W-1:0] rd_data
);
    logic [ADDR_W-1:0] idx_r [NUM_IDX];

    genvar g;
    generate
        for (g = 0; g < NUM_IDX; g++)
        begin : gen_idx
            always_ff @(posedge sys_clk)
            begin
                if (!rstn)
                    idx_r[g] <= ADDR_RST;
                else if (ce && wr_en && wr_sel == VAR_W'(g + 1))
                    idx_r[g] <= wr_data;
            end
        end
    endgenerate

    // Selector codes outside one to six read as zero.
    always_comb
    begin
        rd_data = ADDR_RST;
        for (int i = 0; i < NUM_IDX; i++)
            if (rd_sel == VAR_W'(i + 1))
                rd_data = idx_r[i];
    end
endmodule
`default_nettype wire

//--- hw/iwd_timer.sv
// Down counter that times the execute phase of an instruction.
`timescale 1ns/1ps
`default_nettype none
module iwd_timer
    import iwd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [TMR_W-1:0] count,
    // Status
    output logic busy,
    output logic done
);
    logic [TMR_W-1:0] cnt_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            cnt_r <= '0;
        else if (ce)
        begin
            if (load)
                cnt_r <= count;
            else if (cnt_r != '0)
                cnt_r <= cnt_r - TMR_W'(1);
        end
    end

    assign busy = (cnt_r != '0);
    assign done = (cnt_r == TMR_W'(1));
endmodule
`default_nettype wire

//--- hw/iwd_decoder.sv
// Instruction decoder, address resolver and execution sequencer.
`timescale 1ns/1ps
`default_nettype none
module iwd_decoder
    import iwd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // Instruction intake
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    output logic instr_ready,
    // Memory read port
    output logic mem_req,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [WORD_W-1:0] mem_rdata,
    // Datapath side
    input wire logic [WORD_W-1:0] acc_word,
    input wire logic ext_sig_pin,
    input wire logic periph_skip,
    input wire logic [CNT_W-1:0] xfer_count,
    input wire logic idx_wr_en,
    input wire logic [VAR_W-1:0] idx_wr_sel,
    input wire logic [ADDR_W-1:0] idx_wr_data,
    // Decode results
    output iwd_instr_t instr_fields,
    output logic group_op,
    output logic [ADDR_W-1:0] eff_addr,
    output iwd_data_t operand,
    output logic op_done,
    output logic skip,
    output logic branch,
    // Priority interrupts
    input wire logic [IRQ_LEVELS-1:0] irq_pin,
    output logic irq_active,
    output logic [IRQ_LVL_W-1:0] irq_level
);
    iwd_state_t state_r;
    iwd_state_t state_nxt;
    iwd_instr_t instr_r;
    logic [ADDR_W-1:0] ea_r;
    logic [ADDR_W-1:0] ea_nxt;
    logic [ADDR_W-1:0] mem_addr_r;
    iwd_data_t operand_r;
    logic skip_r;
    logic branch_r;
    logic group_r;
    logic [TMR_W-1:0] budget_r;
    logic [TMR_W-1:0] budget_nxt;
    logic exec_entry;
    logic exec_done;
    logic is_group;
    logic is_index_op;
    logic needs_opnd;
    logic [ADDR_W-1:0] idx_rd;
    logic [ADDR_W-1:0] add_b;
    logic [ADDR_W-1:0] addr_sum;
    logic [WORD_W-1:0] opnd_now;
    logic skip_nxt;
    logic djx_wr;
    logic ix_wr_en;
    logic [VAR_W-1:0] ix_wr_sel;
    logic [ADDR_W-1:0] ix_wr_data;
    logic ext_s1_r;
    logic ext_s2_r;
    logic [IRQ_LEVELS-1:0] irq_s1_r;
    logic [IRQ_LEVELS-1:0] irq_s2_r;
    logic irq_active_r;
    logic [IRQ_LVL_W-1:0] irq_level_r;
    logic [TMR_W-1:0] exec_cnt_r;

    // Operations whose variant is not an addressing mode.
    assign is_group = (instr_r.opcode == OPC_GROUP);
    assign is_index_op = (instr_r.opcode == OPC_DJX) ||
        (instr_r.opcode == OPC_SXI) || (instr_r.opcode == OPC_SKX);

    always_comb
    begin
        unique case (instr_r.opcode)
            OPC_ADD, OPC_SUB, OPC_MPY, OPC_DIV, OPC_SKM, OPC_AND,
            OPC_XOR, OPC_IOR, OPC_SST, OPC_SKX:
                needs_opnd = 1'b1;
            default:
                needs_opnd = 1'b0;
        endcase
    end

    // The variant register drives the index selector in every phase.
    iwd_index_regs u_index (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .wr_en(ix_wr_en),
        .wr_sel(ix_wr_sel),
        .wr_data(ix_wr_data),
        .rd_sel(instr_r.variant),
        .rd_data(idx_rd)
    );

    // One fifteen-bit adder serves indexing and index countdown.
    assign add_b = (instr_r.opcode == OPC_DJX) ? ADDR_MINUS_ONE
                                               : instr_r.addr;
    assign addr_sum = idx_rd + add_b;

    // A countdown write wins over a datapath write in the same cycle.
    assign djx_wr = exec_entry && (instr_r.opcode == OPC_DJX);
    assign ix_wr_en = djx_wr || idx_wr_en;
    assign ix_wr_sel = djx_wr ? instr_r.variant : idx_wr_sel;
    assign ix_wr_data = djx_wr ? addr_sum : idx_wr_data;

    always_comb
    begin
        state_nxt = state_r;
        ea_nxt = instr_r.addr;
        unique case (state_r)
            ST_IDLE:
                if (instr_valid)
                    state_nxt = ST_RESOLVE;
            ST_RESOLVE:
            begin
                if (!is_group && !is_index_op &&
                    instr_r.variant == VAR_INDIRECT)
                    state_nxt = ST_IND_WAIT;
                else
                begin
                    if (!is_group && !is_index_op &&
                        instr_r.variant != VAR_DIRECT)
                        ea_nxt = addr_sum;
                    state_nxt = needs_opnd ? ST_OPR_WAIT : ST_EXEC;
                end
            end
            ST_IND_WAIT:
                if (mem_ack)
                    state_nxt = ST_RESOLVE;
            ST_OPR_WAIT:
                if (mem_ack)
                    state_nxt = ST_EXEC;
            ST_EXEC:
                if (exec_done)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    assign exec_entry = (state_r != ST_EXEC) && (state_nxt == ST_EXEC);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            state_r <= ST_IDLE;
        else if (ce)
            state_r <= state_nxt;
    end

    // Field capture on intake and variant/address reload on indirection.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            instr_r <= WORD_RST;
        else if (ce)
        begin
            if (state_r == ST_IDLE && instr_valid)
            begin
                instr_r.opcode <= instr_word[OPC_LSB +: OPC_W];
                instr_r.variant <= instr_word[VAR_LSB +: VAR_W];
                instr_r.addr <= instr_word[ADDR_W-1:0];
            end
            else if (state_r == ST_IND_WAIT && mem_ack)
            begin
                instr_r.variant <= mem_rdata[IND_VAR_LSB +: VAR_W];
                instr_r.addr <= mem_rdata[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            ea_r <= ADDR_RST;
            mem_addr_r <= ADDR_RST;
            group_r <= 1'b0;
        end
        else if (ce && state_r == ST_RESOLVE)
        begin
            ea_r <= ea_nxt;
            mem_addr_r <= (state_nxt == ST_IND_WAIT) ? instr_r.addr
                                                     : ea_nxt;
            group_r <= is_group;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            operand_r <= WORD_RST;
        else if (ce && state_r == ST_OPR_WAIT && mem_ack)
            operand_r <= mem_rdata;
    end

    // Skip decisions are taken as the execute phase starts.
    assign opnd_now = (state_r == ST_OPR_WAIT) ? mem_rdata : operand_r;

    always_comb
    begin
        unique case (instr_r.opcode)
            OPC_SKM:
                skip_nxt = (acc_word == opnd_now);
            OPC_SKE:
                skip_nxt = !ext_s2_r;
            OPC_PIN:
                skip_nxt = periph_skip;
            OPC_SXI:
                skip_nxt = (idx_rd > instr_r.addr);
            OPC_SKX:
                skip_nxt = (idx_rd > opnd_now[ADDR_W-1:0]);
            default:
                skip_nxt = 1'b0;
        endcase
    end

    always_comb
    begin
        unique case (instr_r.opcode)
            OPC_ADD, OPC_SUB:
                budget_nxt = TMR_W'(CYC_ARITH);
            OPC_MPY:
                budget_nxt = TMR_W'(CYC_MPY);
            OPC_DIV:
                budget_nxt = TMR_W'(CYC_DIV);
            OPC_SKM:
                budget_nxt = TMR_W'(CYC_SKM);
            OPC_SKE:
                budget_nxt = TMR_W'(CYC_SKE);
            OPC_PIN:
                budget_nxt = skip_nxt ? TMR_W'(CYC_PIN_SKIP)
                                      : TMR_W'(CYC_PIN_NOSKIP);
            OPC_AND, OPC_XOR, OPC_IOR:
                budget_nxt = TMR_W'(CYC_LOGIC);
            OPC_SST:
                budget_nxt = TMR_W'(CYC_SST);
            OPC_PCB:
                budget_nxt = TMR_W'(CYC_BLK_BASE +
                    CYC_PCB_PER * int'(xfer_count));
            OPC_PDT:
                budget_nxt = TMR_W'(CYC_BLK_BASE +
                    CYC_PDT_PER * int'(xfer_count));
            OPC_DJX:
                budget_nxt = TMR_W'(CYC_DJX);
            OPC_SXI:
                budget_nxt = TMR_W'(CYC_SXI);
            OPC_SKX:
                budget_nxt = TMR_W'(CYC_SKX);
            default:
                budget_nxt = TMR_W'(CYC_OTHER);
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            skip_r <= 1'b0;
            branch_r <= 1'b0;
            budget_r <= '0;
        end
        else if (ce && exec_entry)
        begin
            skip_r <= skip_nxt;
            branch_r <= (instr_r.opcode == OPC_DJX) &&
                (addr_sum != ADDR_RST);
            budget_r <= budget_nxt;
        end
    end

    iwd_timer u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .load(exec_entry),
        .count(budget_nxt),
        .busy(),
        .done(exec_done)
    );

    // Pin inputs pass two flip-flops before use.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            irq_s1_r <= '0;
            irq_s2_r <= '0;
        end
        else if (ce)
        begin
            ext_s1_r <= ext_sig_pin;
            ext_s2_r <= ext_s1_r;
            irq_s1_r <= irq_pin;
            irq_s2_r <= irq_s1_r;
        end
    end

    // Level zero has the highest priority.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            irq_active_r <= 1'b0;
            irq_level_r <= '0;
        end
        else if (ce)
        begin
            irq_active_r <= |irq_s2_r;
            irq_level_r <= '0;
            for (int i = IRQ_LEVELS - 1; i >= 0; i--)
                if (irq_s2_r[i])
                    irq_level_r <= IRQ_LVL_W'(i);
        end
    end

    // Cycle count of the execute phase, read only by a check.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            exec_cnt_r <= '0;
        else if (ce)
            exec_cnt_r <= (state_r == ST_EXEC) ? exec_cnt_r + TMR_W'(1)
                                               : '0;
    end

    assign instr_ready = (state_r == ST_IDLE);
    assign mem_req = (state_r == ST_IND_WAIT) || (state_r == ST_OPR_WAIT);
    assign mem_addr = mem_addr_r;
    assign instr_fields = instr_r;
    assign group_op = group_r;
    assign eff_addr = ea_r;
    assign operand = operand_r;
    assign op_done = (state_r == ST_EXEC) && exec_done;
    assign skip = skip_r;
    assign branch = branch_r;
    assign irq_active = irq_active_r;
    assign irq_level = irq_level_r;

    chk_opcode_split: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && instr_ready && instr_valid |=>
        instr_fields.opcode == $past(instr_word[23:18]) &&
        instr_fields.variant == $past(instr_word[17:15]))
        else $error("Op-code or variant not taken from the word.");
    chk_direct_ea: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && state_r == ST_RESOLVE && !is_group && !is_index_op &&
        instr_r.variant == 3'h0 |=> eff_addr == $past(instr_r.addr))
        else $error("Direct address differs from address field.");
    chk_index_sum: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && state_r == ST_RESOLVE && !is_group && !is_index_op &&
        instr_r.variant != 3'h0 && instr_r.variant != 3'h7 |=>
        eff_addr == 15'($past(instr_r.addr) + $past(idx_rd)))
        else $error("Indexed address is not address plus index.");
    chk_indirect_req: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && state_r == ST_RESOLVE && !is_group && !is_index_op &&
        instr_r.variant == 3'h7 |=> mem_req &&
        mem_addr == $past(instr_r.addr) && !op_done)
        else $error("Indirect word not requested at address field.");
    chk_indirect_reload: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        ce && state_r == ST_IND_WAIT && mem_ack |=> state_r == ST_RESOLVE &&
        instr_fields.variant == $past(mem_rdata[23:21]) &&
        instr_fields.addr == $past(mem_rdata[14:0]))
        else $error("Indirect word not reloaded into variant and address.");
    chk_exec_length: assert property (@(posedge sys_clk) disable iff (!rstn)
        op_done |-> exec_cnt_r + 20'h1 == budget_r)
        else $error("Execute phase length differs from its budget.");
    chk_djx_dec: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && djx_wr |-> ix_wr_data == 15'(idx_rd - 15'h1)
        ##1 branch == ($past(ix_wr_data) != 15'h0))
        else $error("Countdown did not subtract one from the index.");
    chk_skm_skip: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && state_r == ST_OPR_WAIT && mem_ack &&
        instr_r.opcode == OPC_SKM |=>
        skip == ($past(acc_word) == $past(mem_rdata)) &&
        budget_r == 20'h190)
        else $error("Equal-skip decision or time is wrong.");
    chk_irq_prio: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && irq_s2_r[0] |=> irq_active && irq_level == 5'h0)
        else $error("Highest priority interrupt level not reported.");
endmodule
`default_nettype wire

//--- bench/iwd_mem_model.sv
// Behavioural main memory that answers the decoder's read requests.
`timescale 1ns/1ps
`default_nettype none
module iwd_mem_model
    import iwd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Read port
    input wire logic mem_req,
    input wire logic [ADDR_W-1:0] mem_addr,
    output logic mem_ack,
    output logic [WORD_W-1:0] mem_rdata,
    // Answer delay in cycles
    input wire logic [3:0] lat
);
    logic [WORD_W-1:0] mem [32];
    logic [3:0] wait_r;

    // Outside an answer the data lines show the inverse of the last word,
    // so a decoder that samples late never sees a stale match.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= WORD_RST;
            wait_r <= 4'h0;
        end
        else if (mem_ack)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_r <= 4'h0;
        end
        else if (mem_req && wait_r == lat)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[4:0]];
        end
        else if (mem_req)
            wait_r <= wait_r + 4'h1;
    end
endmodule
`default_nettype wire

//--- bench/iwd_decoder_test.sv
// Self-checking testbench of the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module instruction_word_decode_and_timing_test
    import iwd_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic instr_valid = 1'b0;
    logic idx_wr_en = 1'b0;
    logic [23:0] instr_word = 24'h0;
    logic [23:0] acc_word = 24'h0;
    logic [23:0] irq_pin = 24'h0;
    logic [2:0] idx_wr_sel = 3'h0;
    logic [14:0] idx_wr_data = 15'h0;
    logic [3:0] lat = 4'h0;
    logic ext_sig_pin = 1'b0;
    logic periph_skip = 1'b0;
    logic [7:0] xfer_count = 8'h00;
    logic group_op;
    logic instr_ready, mem_req, mem_ack, op_done, skip, branch, irq_active;
    logic [14:0] mem_addr, eff_addr;
    logic [23:0] mem_rdata;
    logic [4:0] irq_level;
    iwd_instr_t instr_fields;
    iwd_data_t operand;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    iwd_decoder dut_u (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .acc_word(acc_word),
        .ext_sig_pin(ext_sig_pin), .periph_skip(periph_skip),
        .xfer_count(xfer_count),
        .idx_wr_en(idx_wr_en), .idx_wr_sel(idx_wr_sel),
        .idx_wr_data(idx_wr_data), .instr_fields(instr_fields),
        .group_op(group_op), .eff_addr(eff_addr), .operand(operand),
        .op_done(op_done), .skip(skip), .branch(branch),
        .irq_pin(irq_pin), .irq_active(irq_active), .irq_level(irq_level));

    iwd_mem_model mem_u (.sys_clk(sys_clk), .rstn(rstn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .lat(lat));

    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            finish_test();
        end
    end

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // Runs one instruction; n ends as the cycles from the last memory
    // answer, or from intake when there was none, to op_done.
    task run(input logic [23:0] w);
        int k;
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(instr_fields, w);
        n = 0;
        k = 0;
        while (op_done !== 1'b1 && k < 9000)
        begin
            @(negedge sys_clk);
            k++;
            if (mem_req === 1'b1 && mem_ack === 1'b1)
                n = 0;
            else
                n++;
        end
        chk(24'(op_done), 24'h1);
    endtask

    task wr_idx(input logic [2:0] sel, input logic [14:0] d);
        @(negedge sys_clk);
        idx_wr_en = 1'b1;
        idx_wr_sel = sel;
        idx_wr_data = d;
        @(negedge sys_clk);
        idx_wr_en = 1'b0;
    endtask

    task t_budget;
        logic [5:0] op [8];
        int cy [8];
        op = '{OPC_ADD, OPC_SUB, OPC_MPY, OPC_DIV,
            OPC_AND, OPC_XOR, OPC_IOR, OPC_SST};
        cy = '{CYC_ARITH, CYC_ARITH, CYC_MPY, CYC_DIV,
            CYC_LOGIC, CYC_LOGIC, CYC_LOGIC, CYC_SST};
        for (int i = 0; i < 8; i++)
        begin
            lat = 4'(i);
            run({op[i], VAR_DIRECT, 15'h0004});
            chk(24'(n), 24'(cy[i]));
            chk(24'(eff_addr), 24'h4);
            chk(operand, 24'ha50004);
        end
        lat = 4'h0;
    endtask

    task t_index;
        for (int i = 1; i <= 6; i++)
        begin
            wr_idx(3'(i), 15'h7ff9 + 15'(i));
            run({OPC_ADD, 3'(i), 15'h0008});
            chk(24'(eff_addr), 24'(i + 1));
        end
    endtask

    task t_indirect;
        mem_u.mem[10] = {VAR_INDIRECT, 6'h2a, 15'd11};
        mem_u.mem[11] = {3'h2, 6'h15, 15'd20};
        lat = 4'h2;
        run({OPC_ADD, VAR_INDIRECT, 15'd10});
        chk(24'(eff_addr), 24'd15);
        chk(operand, 24'ha5000f);
        chk(24'(instr_fields.addr), 24'h14);
        lat = 4'h0;
    endtask

    task t_skip;
        mem_u.mem[6] = 24'h801234;
        acc_word = 24'h801234;
        run({OPC_SKM, VAR_DIRECT, 15'd6});
        chk(24'(n), 24'(CYC_SKM));
        chk(24'(skip), 24'h1);
        chk(24'(operand.sign), 24'h1);
        acc_word = 24'h001234;
        run({OPC_SKM, VAR_DIRECT, 15'd6});
        chk(24'(skip), 24'h0);
    endtask

    task t_countdown;
        wr_idx(3'h1, 15'h0002);
        run({OPC_DJX, 3'h1, 15'h0000});
        chk(24'(branch), 24'h1);
        run({OPC_DJX, 3'h1, 15'h0000});
        chk(24'(branch), 24'h0);
    endtask

    task t_irq;
        irq_pin = 24'h000a00;
        repeat (5) @(negedge sys_clk);
        chk(24'(irq_active), 24'h1);
        chk(24'(irq_level), 24'd9);
        irq_pin = 24'h800001;
        repeat (5) @(negedge sys_clk);
        chk(24'(irq_level), 24'h0);
        irq_pin = 24'h0;
        repeat (5) @(negedge sys_clk);
        chk(24'(irq_active), 24'h0);
    endtask

    task t_misc;
        run({OPC_SKE, VAR_DIRECT, 15'h0000});
        chk(24'(skip), 24'h1);
        ext_sig_pin = 1'b1;
        run({OPC_SKE, VAR_DIRECT, 15'h0000});
        chk(24'(skip), 24'h0);
        chk(24'(n), 24'(CYC_SKE));
        ext_sig_pin = 1'b0;
        periph_skip = 1'b1;
        run({OPC_PIN, VAR_DIRECT, 15'h0000});
        chk(24'(n), 24'(CYC_PIN_SKIP));
        periph_skip = 1'b0;
        run({OPC_PIN, VAR_DIRECT, 15'h0000});
        chk(24'(n), 24'(CYC_PIN_NOSKIP));
        xfer_count = 8'h02;
        run({OPC_PCB, VAR_DIRECT, 15'h0000});
        chk(24'(n), 24'(CYC_BLK_BASE + 2 * CYC_PCB_PER));
        xfer_count = 8'h01;
        run({OPC_PDT, VAR_DIRECT, 15'h0000});
        chk(24'(n), 24'(CYC_BLK_BASE + CYC_PDT_PER));
        wr_idx(3'h3, 15'h0010);
        run({OPC_SXI, 3'h3, 15'h000f});
        chk(24'(skip), 24'h1);
        chk(24'(n), 24'(CYC_SXI));
        mem_u.mem[7] = 24'h000010;
        run({OPC_SKX, 3'h3, 15'h0007});
        chk(24'(skip), 24'h0);
        chk(24'(n), 24'(CYC_SKX));
        chk(24'(group_op), 24'h0);
        run({OPC_GROUP, VAR_INDIRECT, 15'h0009});
        chk(24'(group_op), 24'h1);
        chk(24'(eff_addr), 24'h9);
        chk(24'(n), 24'(CYC_OTHER));
    endtask

    initial
    begin
        for (int i = 0; i < 32; i++)
            mem_u.mem[i] = 24'ha50000 + 24'(i);
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        chk(24'(instr_ready), 24'h1);
        chk(24'(mem_req), 24'h0);
        t_budget();
        t_index();
        t_indirect();
        t_skip();
        t_countdown();
        t_misc();
        t_irq();
        finish_test();
    end
endmodule
`default_nettype wire
